// ---- mbw_regs.sv ----
`timescale 1ns/1ps
module mbw_regs (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic [mbw_pkg::ADDR_W-1:0] host_addr, // host address lines
  input wire logic [mbw_pkg::DATA_W-1:0] host_wdata, // host write data
  input wire logic host_rd, // read strobe, one cycle
  input wire logic host_wr, // write strobe, one cycle
  input wire logic loader_holds_card_lock, // loader owns card controller
  input wire logic host_holds_card_lock, // host port owns card controller
  input wire logic loader_fault_flag, // loader fault present
  input wire logic card_ctrl_fault_flag, // card controller fault present
  input wire logic buffer_ready_flag, // data buffer ready
  input wire logic [31:0] upper_status, // remaining status bits from elsewhere
  output logic [mbw_pkg::DATA_W-1:0] host_rdata, // read data, registered
  output logic host_rdata_oe, // drive enable for data lines
  output logic word_width_bit // current port width, 1 = word
);
  import mbw_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic width_ff;
  logic nxt_width;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic oe_ff;
  logic nxt_oe;
  logic [31:0] status_word;
  logic hit_width;

  // bits 0..3 and 5 come from live flags; upper bits pass through with ours masked
  always_comb begin
    status_word = upper_status;
    status_word[LOADER_LOCK_POS] = loader_holds_card_lock;
    status_word[HOST_LOCK_POS] = host_holds_card_lock;
    status_word[LOADER_FAULT_POS] = loader_fault_flag;
    status_word[CARD_FAULT_POS] = card_ctrl_fault_flag;
    status_word[BUFFER_READY_POS] = buffer_ready_flag;
  end

  // word mode ignores address line 0 so both bytes alias one word
  always_comb begin
    if (width_ff) begin
      hit_width = (host_addr[6:1] == WORD_ADDR_WIDTH);
    end else begin
      hit_width = (host_addr == BYTE_ADDR_WIDTH_LO) || (host_addr == BYTE_ADDR_WIDTH_HI);
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // width write honoured in either mode; only bit 0 is stored
  always_comb begin
    nxt_width = width_ff;
    if (host_wr && hit_width) begin
      nxt_width = host_wdata[WORD_WIDTH_BIT_POS];
    end
    nxt_oe = host_rd;
    nxt_rdata = RDATA_RST;
    if (host_rd) begin
      if (width_ff) begin
        unique case (host_addr[6:1])
          WORD_ADDR_WIDTH: nxt_rdata = {15'h0000, width_ff};
          WORD_ADDR_STATUS_LO: nxt_rdata = status_word[15:0];
          WORD_ADDR_STATUS_HI: nxt_rdata = status_word[31:16];
          default: nxt_rdata = RDATA_RST;
        endcase
      end else begin
        // byte mode: upper data lines stay zero
        unique case (host_addr)
          BYTE_ADDR_WIDTH_LO, BYTE_ADDR_WIDTH_HI: nxt_rdata = {15'h0000, width_ff};
          BYTE_ADDR_STATUS_B0: nxt_rdata = {8'h00, status_word[7:0]};
          BYTE_ADDR_STATUS_B1: nxt_rdata = {8'h00, status_word[15:8]};
          BYTE_ADDR_STATUS_B2: nxt_rdata = {8'h00, status_word[23:16]};
          BYTE_ADDR_STATUS_B3: nxt_rdata = {8'h00, status_word[31:24]};
          default: nxt_rdata = RDATA_RST;
        endcase
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      width_ff <= WIDTH_SELECT_RST;
      rdata_ff <= RDATA_RST;
      oe_ff <= 1'b0;
    end else begin
      width_ff <= nxt_width;
      rdata_ff <= nxt_rdata;
      oe_ff <= nxt_oe;
    end
  end

  // outputs straight from the flops, no logic after them
  assign host_rdata = rdata_ff;
  assign host_rdata_oe = oe_ff;
  assign word_width_bit = width_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // a release of reset must find the port in byte mode
  AST_RESET_BYTE: assert property (
    @(posedge ref_clk) $rose(rst_b) |-> !word_width_bit)
    else $error("width bit not zero after reset");

  // the upper byte alias writes the same bit as the lower one
  AST_WRITE_ALIAS_HI: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_wr && !word_width_bit && host_addr == BYTE_ADDR_WIDTH_HI)
    |=> (word_width_bit == $past(host_wdata[WORD_WIDTH_BIT_POS])))
    else $error("byte alias 0x01 did not update width");

  // word mode must still accept a width write at word 0
  AST_WRITE_WORD: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_wr && word_width_bit && host_addr[6:1] == WORD_ADDR_WIDTH)
    |=> (word_width_bit == $past(host_wdata[WORD_WIDTH_BIT_POS])))
    else $error("word mode write to width ignored");

  // byte mode leaves data lines 15:8 quiet on every read
  AST_BYTE_UPPER_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && !word_width_bit) |=> (host_rdata[15:8] == 8'h00))
    else $error("byte mode drove upper data lines");

  // word mode drops address line 0, so 0x05 reads the low status half
  AST_WORD_A0_IGNORED: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && word_width_bit && host_addr == BYTE_ADDR_STATUS_B1)
    |=> (host_rdata[LOADER_LOCK_POS] == $past(loader_holds_card_lock))
    && (host_rdata[HOST_LOCK_POS] == $past(host_holds_card_lock)))
    else $error("word mode did not ignore address line 0");

  // status byte 0 carries the live lock, fault and ready flags
  AST_LOADER_LOCK: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && !word_width_bit && host_addr == BYTE_ADDR_STATUS_B0)
    |=> (host_rdata[LOADER_LOCK_POS] == $past(loader_holds_card_lock)))
    else $error("status bit 0 mismatch");
  AST_HOST_LOCK: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && !word_width_bit && host_addr == BYTE_ADDR_STATUS_B0)
    |=> (host_rdata[HOST_LOCK_POS] == $past(host_holds_card_lock)))
    else $error("status bit 1 mismatch");
  AST_LOADER_FAULT: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && !word_width_bit && host_addr == BYTE_ADDR_STATUS_B0)
    |=> (host_rdata[LOADER_FAULT_POS] == $past(loader_fault_flag)))
    else $error("status bit 2 mismatch");
  AST_CARD_FAULT: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && !word_width_bit && host_addr == BYTE_ADDR_STATUS_B0)
    |=> (host_rdata[CARD_FAULT_POS] == $past(card_ctrl_fault_flag)))
    else $error("status bit 3 mismatch");
  AST_BUF_READY: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && !word_width_bit && host_addr == BYTE_ADDR_STATUS_B0)
    |=> (host_rdata[BUFFER_READY_POS] == $past(buffer_ready_flag)))
    else $error("status bit 5 mismatch");

  // the top status byte passes the other status bits through untouched
  AST_BYTE_STATUS_TOP: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && !word_width_bit && host_addr == BYTE_ADDR_STATUS_B3)
    |=> (host_rdata[7:0] == $past(upper_status[31:24])))
    else $error("byte mode top status byte mismatch");

  // reserved bits of the width register read zero at every alias
  AST_RESERVED_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && hit_width) |=> (host_rdata[15:1] == 15'h0000))
    else $error("width register reserved bits not zero");

  // only a decoded width write may move the stored bit
  AST_WIDTH_HOLD: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !(host_wr && hit_width) |=> $stable(word_width_bit))
    else $error("width bit moved without a width write");

  // every alias reads back the one stored bit
  AST_WIDTH_READBACK: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && hit_width)
    |=> (host_rdata[WORD_WIDTH_BIT_POS] == $past(word_width_bit)))
    else $error("width register read back wrong value");

  // data lines driven in the cycle after a read, and only then
  AST_OE_AFTER_READ: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    host_rd |=> host_rdata_oe)
    else $error("read data not driven after read");
  AST_IDLE_QUIET: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !host_rd |=> (!host_rdata_oe && host_rdata == RDATA_RST))
    else $error("read data driven without a read");

  // word reads of the low status half carry the fault and ready flags
  AST_WORD_FLAGS: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && word_width_bit && host_addr[6:1] == WORD_ADDR_STATUS_LO)
    |=> (host_rdata[LOADER_FAULT_POS] == $past(loader_fault_flag))
    && (host_rdata[CARD_FAULT_POS] == $past(card_ctrl_fault_flag))
    && (host_rdata[BUFFER_READY_POS] == $past(buffer_ready_flag)))
    else $error("word mode status flags mismatch");

  // the high status half passes the other status bits through untouched
  AST_WORD_STATUS_HI: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (host_rd && word_width_bit && host_addr[6:1] == WORD_ADDR_STATUS_HI)
    |=> (host_rdata == $past(upper_status[31:16])))
    else $error("word mode high status half mismatch");

  // main scenarios: both mode changes, status reads in each mode and a width write in word mode
  COV_TO_WORD: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(word_width_bit));
  COV_TO_BYTE: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(word_width_bit));
  COV_WORD_STATUS: cover property (@(posedge ref_clk) disable iff (!rst_b)
    host_rd && word_width_bit && host_addr[6:1] == WORD_ADDR_STATUS_LO);
  COV_BYTE_STATUS: cover property (@(posedge ref_clk) disable iff (!rst_b)
    host_rd && !word_width_bit && host_addr == BYTE_ADDR_STATUS_B0);
  COV_WORD_WIDTH_WRITE: cover property (@(posedge ref_clk) disable iff (!rst_b)
    host_wr && word_width_bit && hit_width);
endmodule

// ---- mbw_pkg.sv ----
package mbw_pkg;
  // ----------------------------------------
  // host port geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  // ----------------------------------------
  // register map, byte addresses and word addresses
  // ----------------------------------------
  localparam logic [6:0] BYTE_ADDR_WIDTH_LO = 7'h00;
  localparam logic [6:0] BYTE_ADDR_WIDTH_HI = 7'h01;
  localparam logic [5:0] WORD_ADDR_WIDTH = 6'h00;
  localparam logic [6:0] BYTE_ADDR_STATUS_B0 = 7'h04;
  localparam logic [6:0] BYTE_ADDR_STATUS_B1 = 7'h05;
  localparam logic [6:0] BYTE_ADDR_STATUS_B2 = 7'h06;
  localparam logic [6:0] BYTE_ADDR_STATUS_B3 = 7'h07;
  localparam logic [5:0] WORD_ADDR_STATUS_LO = 6'h02;
  localparam logic [5:0] WORD_ADDR_STATUS_HI = 6'h03;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int unsigned WORD_WIDTH_BIT_POS = 0;
  localparam logic WIDTH_SELECT_RST = 1'b0;
  localparam int unsigned LOADER_LOCK_POS = 0;
  localparam int unsigned HOST_LOCK_POS = 1;
  localparam int unsigned LOADER_FAULT_POS = 2;
  localparam int unsigned CARD_FAULT_POS = 3;
  localparam int unsigned BUFFER_READY_POS = 5;
  localparam logic [15:0] RDATA_RST = 16'h0000;
endpackage

// ---- mbw_host_model.sv ----
`timescale 1ns/1ps
module mbw_host_model (
  input wire logic ref_clk, // bus clock
  input wire logic [mbw_pkg::DATA_W-1:0] host_rdata, // read data
  input wire logic host_rdata_oe, // device drives data
  output logic [mbw_pkg::ADDR_W-1:0] host_addr, // address lines
  output logic [mbw_pkg::DATA_W-1:0] host_wdata, // write data
  output logic host_rd, // read strobe
  output logic host_wr // write strobe
);
  import mbw_pkg::*;
  initial begin
    host_addr = 7'h00;
    host_wdata = 16'h0000;
    host_rd = 1'b0;
    host_wr = 1'b0;
  end
  // two cycles per call, strobe high for one; freed lines invert so stale values never match
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic oe);
    @(posedge ref_clk);
    host_addr <= a;
    host_wdata <= d;
    host_rd <= rd;
    host_wr <= !rd;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
    #1 q = host_rdata;
    oe = host_rdata_oe;
  endtask
endmodule

// ---- mbw_regs_test.sv ----
`timescale 1ns/1ps
module mbw_regs_test;
  import mbw_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] fl = 5'h00;
  logic [31:0] us = 32'h0000_0000;
  logic [ADDR_W-1:0] host_addr;
  logic [DATA_W-1:0] host_wdata, host_rdata, q;
  logic host_rd, host_wr, host_rdata_oe, word_width_bit, oe;
  logic [31:0] e;
  logic [15:0] xb;
  int miscompares = 0;
  int compares = 0;
  mbw_regs dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr),
    .loader_holds_card_lock(fl[0]), .host_holds_card_lock(fl[1]),
    .loader_fault_flag(fl[2]), .card_ctrl_fault_flag(fl[3]),
    .buffer_ready_flag(fl[4]), .upper_status(us), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .word_width_bit(word_width_bit));
  mbw_host_model host_u (.ref_clk(ref_clk), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr));
  initial forever #12.5 ref_clk = ~ref_clk;
  // flags land on bits 0..3 and 5, the rest passes through
  function automatic logic [31:0] st();
    return {us[31:6], fl[4], us[4], fl[3:0]};
  endfunction
  task automatic chk(input string w, input logic [15:0] x, input logic [15:0] g);
    compares++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", w, x, g);
      miscompares++;
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [15:0] x);
    host_u.xfer(1'b1, a, 16'h0000, q, oe);
    chk("host_rdata", x, q);
    chk("host_rdata_oe", 16'h0001, {15'h0000, oe});
  endtask
  task automatic wrc(input logic [6:0] a, input logic [15:0] d, input logic x);
    host_u.xfer(1'b0, a, d, q, oe);
    chk("word_width_bit", {15'h0000, x}, {15'h0000, word_width_bit});
    chk("host_rdata", 16'h0000, q);
    chk("host_rdata_oe", 16'h0000, {15'h0000, oe});
  endtask
  // ---
  // scenarios
  // ---
  task automatic t_reset;
    chk("word_width_bit", 16'h0000, {15'h0000, word_width_bit});
    rdc(BYTE_ADDR_WIDTH_HI, 16'h0000);
  endtask
  // each flag alone, upper bits all-zero for even flags and all-ones for odd ones, then no flag
  task automatic t_status;
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      fl <= 5'h01 << i;
      us <= {32{i[0]}};
      #1 e = st();
      for (int b = 0; b < 4; b++) begin
        xb = {8'h00, e[8*b +: 8]};
        rdc(BYTE_ADDR_STATUS_B0 + 7'(b), xb);
      end
    end
  endtask
  task automatic t_word;
    // host lock and ready set, loader lock clear, so bits 0 and 1 differ
    @(posedge ref_clk);
    fl <= 5'h12;
    #1 e = st();
    wrc(BYTE_ADDR_WIDTH_HI, 16'hFFFF, 1'b1);
    rdc(7'h01, 16'h0001);
    rdc(7'h05, e[15:0]);
    wrc(7'h06, 16'h0000, 1'b1);
    rdc(7'h06, e[31:16]);
    rdc(7'h02, 16'h0000);
    wrc(7'h00, 16'h0000, 1'b0);
    wrc(BYTE_ADDR_WIDTH_LO, 16'h0001, 1'b1);
    wrc(BYTE_ADDR_WIDTH_HI, 16'hFFFE, 1'b0);
    rdc(7'h03, 16'h0000);
  endtask
  // a reset in mid-run must drop a word-mode port back to byte mode
  task automatic t_rerst;
    wrc(BYTE_ADDR_WIDTH_LO, 16'h0001, 1'b1);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("word_width_bit", 16'h0000, {15'h0000, word_width_bit});
    rst_b <= 1'b1;
    rdc(BYTE_ADDR_WIDTH_LO, 16'h0000);
  endtask
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_status;
    t_word;
    t_rerst;
    complete_run;
  end
  // bound on the whole run in case a cycle never returns
  initial begin
    repeat (2000) @(posedge ref_clk);
    miscompares++;
    complete_run;
  end
endmodule
